// ===== rtl/hcx_ctrl.sv
/*
 Mode control and digital data path of a high-speed CAN FD transceiver.
 Assumes synchronous inputs, a 200 MHz clock, and an analog front end that
 turns the line pair into bus_dominant_i and bus_drive_o into line levels.
*/
`timescale 1ns/1ps
`include "hcx_defines.svh"

module hcx_ctrl #(
  parameter int SETTLE_CYC = `HCX_SETTLE_CYC,
  parameter int TXTO_CYC = `HCX_TXTO_CYC,
  parameter int WAKE1_CYC = `HCX_WAKE1_CYC,
  parameter int WAKE2_CYC = `HCX_WAKE2_CYC,
  parameter int FIFO_DEPTH = `HCX_FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire hcx_pkg::hcx_chip_t chip_mode_i,
  input wire hcx_pkg::hcx_mode_t mode_wr_data_i,
  input wire logic mode_wr_i,
  output hcx_pkg::hcx_mode_t mode_o,
  input wire logic tx_data_in_i,
  output logic rx_data_out_o,
  input wire logic bus_dominant_i,
  output logic bus_drive_o,
  output logic rx_enable_o,
  output logic settled_o,
  output logic fail_o,
  input wire logic fail_clr_i,
  output logic wake_event_o,
  output hcx_pkg::hcx_sample_t sample_data_o,
  output logic sample_valid_o,
  input wire logic sample_ready_i,
  output logic sample_overrun_o
);
  import hcx_pkg::*;

  localparam int CW = $clog2(TXTO_CYC + 2);

  initial begin
    if (SETTLE_CYC < 1 || TXTO_CYC < 1 || WAKE1_CYC < 1 || WAKE2_CYC <= WAKE1_CYC) begin
      $error("Timing counts out of range");
    end
    if (SETTLE_CYC >= TXTO_CYC || WAKE2_CYC > TXTO_CYC) begin
      $error("Counters are sized from TXTO_CYC");
    end
  end

  function automatic logic mode_allowed(input hcx_mode_t m, input hcx_chip_t c);
    case (m)
      `HCX_MODE_OFF: mode_allowed = 1'b1;
      `HCX_MODE_NORMAL: mode_allowed = (c == `HCX_CHIP_NORMAL);
      `HCX_MODE_RXONLY: mode_allowed = (c == `HCX_CHIP_NORMAL) || (c == `HCX_CHIP_STOP);
      `HCX_MODE_WAKE: mode_allowed = 1'b1;
      default: mode_allowed = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mode register
  hcx_mode_t mode;
  hcx_chip_t chip_prev;
  hcx_state_t state;
  hcx_state_t next_state;
  hcx_wup_t wup;
  hcx_wup_t next_wup;
  logic [CW-1:0] settle_cnt;
  logic [CW-1:0] dom_cnt;
  logic [CW-1:0] wup_cnt;
  logic tx_prev;
  logic tx_blocked;
  logic woken;
  logic rx_hold;

  wire failsafe = (chip_mode_i == `HCX_CHIP_FAILSAFE);
  wire wr_ok = mode_wr_i && mode_allowed(mode_wr_data_i, chip_mode_i);
  wire cur_ok = mode_allowed(mode, chip_mode_i);
  // Wake-capable is forced only on entry into Fail-Safe, so Off stays selectable
  wire fs_entry = failsafe && (chip_mode_i != chip_prev);
  // Fail-Safe forces Wake-capable; other illegal modes drop back to Off
  wire hcx_mode_t fallback = failsafe ? `HCX_MODE_WAKE : `HCX_MODE_OFF;
  wire mode_change = wr_ok && (mode_wr_data_i != mode);
  wire rearm_chip = (chip_mode_i != chip_prev) && ((chip_mode_i == `HCX_CHIP_STOP) ||
                    (chip_mode_i == `HCX_CHIP_SLEEP) || failsafe);
  // A rewrite of 01 while already in 01 does not rearm
  wire rearm = mode_change || rearm_chip;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mode <= `HCX_MODE_OFF;
      chip_prev <= `HCX_CHIP_NORMAL;
    end else begin
      chip_prev <= chip_mode_i;
      if (wr_ok) begin
        mode <= mode_wr_data_i;
      end else if (!cur_ok || fs_entry) begin
        mode <= fallback;
      end
    end
  end

  assign mode_o = mode;

  ////////////////////////////////////////////////////////////////////////////
  // Transceiver state
  always_comb begin
    next_state = state;
    case (state)
      HCX_ST_OFF: begin
        if (mode == `HCX_MODE_NORMAL) next_state = HCX_ST_SETTLE;
        else if (mode == `HCX_MODE_RXONLY) next_state = HCX_ST_ACTIVE;
        else if (mode == `HCX_MODE_WAKE) next_state = HCX_ST_WAKE;
      end
      HCX_ST_SETTLE: begin
        if (mode != `HCX_MODE_NORMAL) next_state = HCX_ST_OFF;
        else if (settle_cnt >= CW'(SETTLE_CYC - 1)) next_state = HCX_ST_ACTIVE;
      end
      HCX_ST_ACTIVE: begin
        if (mode_change || mode == `HCX_MODE_OFF || mode == `HCX_MODE_WAKE) begin
          next_state = HCX_ST_OFF;
        end
      end
      HCX_ST_WAKE: begin
        if (mode != `HCX_MODE_WAKE) next_state = HCX_ST_OFF;
      end
      default: next_state = HCX_ST_OFF;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= HCX_ST_OFF;
      settle_cnt <= '0;
    end else begin
      state <= next_state;
      settle_cnt <= (state == HCX_ST_SETTLE) ? settle_cnt + 1'b1 : '0;
    end
  end

  assign settled_o = (state == HCX_ST_ACTIVE) && (mode == `HCX_MODE_NORMAL);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path with early-dominant suppression and time-out
  wire normal_tx = settled_o;
  wire tx_dom = !tx_data_in_i;
  wire tx_fall = tx_prev && tx_dom;
  // Saturating count keeps the time-out up for as long as dominant lasts
  wire txto_hit = normal_tx && tx_dom && (dom_cnt >= CW'(TXTO_CYC - 1));

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_prev <= 1'b1;
      tx_blocked <= 1'b1;
      dom_cnt <= '0;
      fail_o <= 1'b0;
    end else begin
      tx_prev <= tx_data_in_i;
      // Only a dominant edge seen after settling may reach the bus
      if (!normal_tx) tx_blocked <= 1'b1;
      else if (tx_fall || !tx_dom) tx_blocked <= 1'b0;
      dom_cnt <= (normal_tx && tx_dom) ? ((dom_cnt == CW'(TXTO_CYC)) ? dom_cnt : dom_cnt + 1'b1)
                                       : '0;
      // Set wins over clear
      if (txto_hit) fail_o <= 1'b1;
      else if (fail_clr_i) fail_o <= 1'b0;
    end
  end

  // Drive dominant only while enabled, unsuppressed and not timed out
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      bus_drive_o <= 1'b0;
    end else begin
      // A fresh fall on the first settled cycle passes before the block clears
      bus_drive_o <= normal_tx && tx_dom && (!tx_blocked || tx_fall) &&
                     !txto_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up pattern detector
  wire in_wake = (state == HCX_ST_WAKE);
  // Phase length is counted afresh on every change of phase
  wire over1 = (wup_cnt >= CW'(WAKE1_CYC));
  wire under2 = (wup_cnt < CW'(WAKE2_CYC));

  always_comb begin
    next_wup = wup;
    case (wup)
      HCX_WP_IDLE: if (bus_dominant_i) next_wup = HCX_WP_DOM1;
      HCX_WP_DOM1: begin
        if (!under2) next_wup = HCX_WP_IDLE;
        else if (!bus_dominant_i) next_wup = over1 ? HCX_WP_REC : HCX_WP_IDLE;
      end
      HCX_WP_REC: begin
        if (!under2) next_wup = HCX_WP_IDLE;
        else if (bus_dominant_i) next_wup = over1 ? HCX_WP_DOM2 : HCX_WP_DOM1;
      end
      HCX_WP_DOM2: begin
        if (!under2) next_wup = HCX_WP_IDLE;
        else if (!bus_dominant_i) next_wup = over1 ? HCX_WP_DONE : HCX_WP_IDLE;
      end
      HCX_WP_DONE: next_wup = HCX_WP_IDLE;
      default: next_wup = HCX_WP_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i || !in_wake || woken) begin
      wup <= HCX_WP_IDLE;
      wup_cnt <= '0;
    end else begin
      wup <= next_wup;
      wup_cnt <= (next_wup != wup) ? '0 : (under2 ? wup_cnt + 1'b1 : wup_cnt);
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      woken <= 1'b0;
      wake_event_o <= 1'b0;
    end else begin
      wake_event_o <= in_wake && !woken && (wup == HCX_WP_DONE);
      if (in_wake && wup == HCX_WP_DONE) woken <= 1'b1;
      else if (rearm || !in_wake) woken <= 1'b0;
    end
  end

  // Receive hold outlives a chip-mode rearm; only leaving Wake-capable ends it
  always_ff @(posedge clock_i) begin
    if (reset_i || !in_wake) begin
      rx_hold <= 1'b0;
    end else if (wup == HCX_WP_DONE) begin
      rx_hold <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path
  wire rx_on = (state == HCX_ST_ACTIVE) || (state == HCX_ST_SETTLE);
  assign rx_enable_o = rx_on;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_data_out_o <= 1'b1;
    end else if (in_wake && rx_hold) begin
      rx_data_out_o <= 1'b0;
    end else begin
      rx_data_out_o <= rx_on ? !bus_dominant_i : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic sample stream of receive level changes and wake events
  hcx_sample_t smp;
  logic rx_last;
  logic smp_ready;
  wire smp_valid = ((rx_data_out_o != rx_last) && rx_on) || wake_event_o;
  assign smp = '{rx_level: rx_data_out_o, wake: wake_event_o};

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_last <= 1'b1;
      sample_overrun_o <= 1'b0;
    end else begin
      rx_last <= rx_data_out_o;
      if (smp_valid && !smp_ready) sample_overrun_o <= 1'b1;
      else if (state == HCX_ST_OFF) sample_overrun_o <= 1'b0;
    end
  end

  hcx_fifo #(
    .WIDTH($bits(hcx_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_data_i(smp),
    .in_valid_i(smp_valid),
    .in_ready_o(smp_ready),
    .out_data_o(sample_data_o),
    .out_valid_o(sample_valid_o),
    .out_ready_i(sample_ready_i)
  );
endmodule

// ===== rtl/hcx_defines.svh
/*
 Timing counts, mode codes and chip-mode codes for the CAN transceiver mode control.
 Assumes a 200 MHz core clock.
*/
`ifndef HCX_DEFINES_SVH
`define HCX_DEFINES_SVH

`define HCX_CLK_MHZ 200
// Mode field codes
`define HCX_MODE_OFF 2'h0
`define HCX_MODE_WAKE 2'h1
`define HCX_MODE_RXONLY 2'h2
`define HCX_MODE_NORMAL 2'h3
// Chip operating modes
`define HCX_CHIP_NORMAL 3'h0
`define HCX_CHIP_STOP 3'h1
`define HCX_CHIP_SLEEP 3'h2
`define HCX_CHIP_RESTART 3'h3
`define HCX_CHIP_FAILSAFE 3'h4
// Times in microseconds, as plain figures, and the top bit rate in bit/s
`define HCX_SETTLE_US 50
`define HCX_TXTO_US 2000
`define HCX_WAKE1_US 1
`define HCX_WAKE2_US 1000
`define HCX_MAX_BAUD 2000000
// Cycle counts derived from the clock rate, and the sample FIFO depth
`define HCX_SETTLE_CYC (`HCX_SETTLE_US * `HCX_CLK_MHZ)
`define HCX_TXTO_CYC (`HCX_TXTO_US * `HCX_CLK_MHZ)
`define HCX_WAKE1_CYC (`HCX_WAKE1_US * `HCX_CLK_MHZ)
`define HCX_WAKE2_CYC (`HCX_WAKE2_US * `HCX_CLK_MHZ)
`define HCX_FIFO_DEPTH 32

`endif

// ===== rtl/hcx_pkg.sv
/*
 Types for the CAN transceiver mode control.
 Assumes hcx_defines.svh supplies the numeric codes.
*/
package hcx_pkg;
  typedef logic [1:0] hcx_mode_t;
  typedef logic [2:0] hcx_chip_t;

  typedef struct packed {
    logic rx_level;
    logic wake;
  } hcx_sample_t;

  typedef enum logic [3:0] {
    HCX_ST_OFF = 4'h1,
    HCX_ST_SETTLE = 4'h2,
    HCX_ST_ACTIVE = 4'h4,
    HCX_ST_WAKE = 4'h8
  } hcx_state_t;

  typedef enum logic [4:0] {
    HCX_WP_IDLE = 5'h01,
    HCX_WP_DOM1 = 5'h02,
    HCX_WP_REC = 5'h04,
    HCX_WP_DOM2 = 5'h08,
    HCX_WP_DONE = 5'h10
  } hcx_wup_t;
endpackage

// ===== rtl/hcx_fifo.sv
/*
 Small flip-flop FIFO with valid/ready on both sides.
 Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module hcx_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("DEPTH must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [WIDTH-1:0] head;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid_i && !full;
  wire pop = out_valid_o && out_ready_i;
  wire load = !out_valid_o || pop;

  assign in_ready_o = !full;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        out_valid_o <= !empty;
        if (!empty) begin
          out_data_o <= mem[rd_ptr[AW-1:0]];
          rd_ptr <= rd_ptr + 1'b1;
        end
      end
    end
  end
endmodule

// ===== verif/hcx_ctrl_monitor.sv
/* Port checker for hcx_ctrl.
 Bound to the design from the bench; sees only the top module's ports. */
`timescale 1ns/1ps
module hcx_ctrl_monitor #(
  parameter int TXTO_CYC = 64
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire hcx_pkg::hcx_chip_t chip_mode_i,
  input wire hcx_pkg::hcx_mode_t mode_wr_data_i,
  input wire logic mode_wr_i,
  input wire hcx_pkg::hcx_mode_t mode_o,
  input wire logic tx_data_in_i,
  input wire logic rx_data_out_o,
  input wire logic bus_dominant_i,
  input wire logic bus_drive_o,
  input wire logic rx_enable_o,
  input wire logic settled_o,
  input wire logic fail_o,
  input wire logic wake_event_o
);
  import hcx_pkg::*;
  int drive_run;
  always_ff @(posedge clock_i) begin
    if (reset_i || !bus_drive_o) begin
      drive_run <= 0;
    end else begin
      drive_run <= drive_run + 1;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  reset_off_a: assert property (disable iff (1'b0)
    reset_i |=> mode_o == 2'h0 && !bus_drive_o && rx_data_out_o && !fail_o)
    else $error("reset state wrong");
  refuse_normal_a: assert property (
    mode_wr_i && mode_wr_data_i == 2'h3 && chip_mode_i != 3'h0 && mode_o != 2'h3
    |=> mode_o != 2'h3) else $error("normal taken outside chip normal");
  drive_cause_a: assert property (
    $rose(bus_drive_o) |-> $past(settled_o) && !$past(tx_data_in_i))
    else $error("dominant without cause");
  recessive_a: assert property (
    (!settled_o || tx_data_in_i) |=> !bus_drive_o) else $error("bus driven");
  rx_follow_a: assert property (
    rx_enable_o |=> rx_data_out_o == !$past(bus_dominant_i))
    else $error("receive output wrong");
  off_quiet_a: assert property (
    mode_o == 2'h0 && $past(mode_o) == 2'h0 && $past(mode_o, 2) == 2'h0
    |-> !wake_event_o ##1 rx_data_out_o) else $error("activity in off");
  wake_low_a: assert property (
    wake_event_o && !mode_wr_i |-> mode_o == 2'h1 ##1 !rx_data_out_o && mode_o == 2'h1)
    else $error("wake reporting wrong");
  wake_hold_a: assert property (
    mode_o == 2'h1 && !rx_data_out_o && !rx_enable_o && !$past(rx_enable_o) &&
    !mode_wr_i && !$past(mode_wr_i) && $stable(chip_mode_i) |=> !rx_data_out_o)
    else $error("wake low released");
  txto_a: assert property (bus_drive_o |-> drive_run < TXTO_CYC)
    else $error("dominant past time-out");
  fail_rel_a: assert property ($rose(fail_o) |-> !bus_drive_o && mode_o == 2'h3)
    else $error("time-out handling wrong");
  cover property (wake_event_o);
  cover property ($rose(fail_o));
  cover property ($rose(settled_o));
endmodule

// ===== verif/hcx_bus_model.sv
/* Far side: the line pair with one remote node on it.
 Assumes high means dominant for both drive requests. */
`timescale 1ns/1ps
module hcx_bus_model (
  input wire logic drive_i,
  input wire logic remote_i,
  output logic dominant_o
);
  // Dominant wins over recessive on the shared pair
  assign dominant_o = drive_i | remote_i;
endmodule

// ===== verif/hcx_ctrl_bench.sv
/* Self-checking bench for hcx_ctrl with the line-pair model.
 Assumes the short counts set below. */
`timescale 1ns/1ps
`include "hcx_defines.svh"
module hcx_ctrl_bench;
  import hcx_pkg::*;
  localparam int SET = 8;
  localparam int TO = 64;
  logic clock_i = 0;
  logic reset_i = 1;
  hcx_chip_t chip = 3'h0;
  hcx_mode_t wr_data = 2'h0;
  hcx_mode_t mode;
  logic wr = 0, tx = 1, clr = 0, rdy = 1, remote = 0;
  logic rx, drive, dom, rx_en, settled, fail, wake, svalid, sover;
  hcx_sample_t sdata;
  int n_fail = 0, checked = 0, got;
  hcx_mode_t exp_q[$];
  always #2.5 clock_i = ~clock_i;
  hcx_ctrl #(.SETTLE_CYC(SET), .TXTO_CYC(TO), .WAKE1_CYC(2), .WAKE2_CYC(16),
    .FIFO_DEPTH(32)) u_dut (.clock_i(clock_i), .reset_i(reset_i), .chip_mode_i(chip),
    .mode_wr_data_i(wr_data), .mode_wr_i(wr), .mode_o(mode), .tx_data_in_i(tx),
    .rx_data_out_o(rx), .bus_dominant_i(dom), .bus_drive_o(drive), .rx_enable_o(rx_en),
    .settled_o(settled), .fail_o(fail), .fail_clr_i(clr), .wake_event_o(wake),
    .sample_data_o(sdata), .sample_valid_o(svalid), .sample_ready_i(rdy),
    .sample_overrun_o(sover));
  hcx_bus_model u_bus (.drive_i(drive), .remote_i(remote), .dominant_o(dom));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] seen);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic wr_mode(input hcx_mode_t m);
    wr_data = m;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(4);
  endtask
  // Two dominant phases split by recessive, all inside the valid window
  task automatic wup();
    int i;
    remote = 1; cyc(5); remote = 0; cyc(5); remote = 1; cyc(5); remote = 0;
    for (i = 0; i < 20 && exp_q.size() != 0; i++) cyc(1);
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("CHECK FAILED wake_event_o expected 1 seen 0");
      complete_run();
    end
    cyc(4);
  endtask
  // Each wake pulse takes the oldest note and compares the mode field
  always @(negedge clock_i) begin
    if (!reset_i && wake === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("wake_event_o", 2'h0, 2'h1);
      end else begin
        chk("mode_o at wake", exp_q.pop_front(), mode);
      end
    end
  end
  initial begin
    void'($urandom(3));
    cyc(12);
    reset_i = 0;
    cyc(1);
    chk("mode_o", `HCX_MODE_OFF, mode);
    chk("rx_data_out_o", 1, rx);
    chk("bus_drive_o", 0, drive);
    chip = `HCX_CHIP_STOP;
    wr_mode(`HCX_MODE_NORMAL);
    chk("mode_o", `HCX_MODE_OFF, mode);
    wr_mode(`HCX_MODE_RXONLY);
    chk("mode_o", `HCX_MODE_RXONLY, mode);
    tx = 0; remote = 1; cyc(3);
    chk("bus_drive_o", 0, drive);
    chk("rx_data_out_o", 0, rx);
    chk("rx_enable_o", 1, rx_en);
    tx = 1; rdy = 0;
    repeat (40) begin remote = ~remote; cyc(2); end
    chk("sample_overrun_o", 1, sover);
    rdy = 1;
    got = 0;
    remote = 0;
    // Head holds the dominant sample, then levels alternate until the FIFO filled
    for (int i = 0; i < 200 && svalid === 1'b1; i++) begin
      if (got < 33) chk("sample_data_o", {got[0], 1'b0}, sdata);
      got++;
      cyc(1);
    end
    chk("sample_valid_o", 0, svalid);
    chk("samples drained", 1, got >= 32);
    chip = `HCX_CHIP_SLEEP; cyc(4);
    chk("mode_o", `HCX_MODE_OFF, mode);
    for (int c = 0; c < 5; c++) begin
      chip = c[2:0];
      wr_mode(`HCX_MODE_WAKE);
      wr_mode(`HCX_MODE_OFF);
      chk("mode_o", `HCX_MODE_OFF, mode);
    end
    chip = `HCX_CHIP_NORMAL;
    tx = 0; // Early dominant on purpose
    wr_mode(`HCX_MODE_NORMAL);
    chk("bus_drive_o", 0, drive);
    cyc(SET + 4);
    chk("settled_o", 1, settled);
    chk("bus_drive_o", 0, drive);
    tx = 1; cyc(2); tx = 0; cyc(2);
    chk("bus_drive_o", 1, drive);
    chk("rx_data_out_o", 0, rx);
    cyc(TO + 4);
    chk("bus_drive_o", 0, drive);
    chk("fail_o", 1, fail);
    chk("mode_o", `HCX_MODE_NORMAL, mode);
    tx = 1; clr = 1; cyc(1); clr = 0; cyc(1); tx = 0; cyc(2);
    chk("bus_drive_o", 1, drive);
    chk("fail_o", 0, fail);
    for (int i = 0; i < 40; i++) begin
      tx = (i % 4 == 3) ? 1'b1 : 1'($urandom() & 1);
      cyc(10);
      chk("bus_drive_o", !tx, drive);
      chk("rx_data_out_o", tx, rx);
    end
    tx = 1; cyc(2);
    wr_mode(`HCX_MODE_WAKE);
    chk("mode_o", `HCX_MODE_WAKE, mode);
    exp_q.push_back(`HCX_MODE_WAKE);
    wup();
    chk("rx_data_out_o", 0, rx);
    wup();
    chk("mode_o", `HCX_MODE_WAKE, mode);
    chk("rx_data_out_o", 0, rx);
    wr_mode(`HCX_MODE_OFF);
    chk("rx_data_out_o", 1, rx);
    wup();
    wr_mode(`HCX_MODE_WAKE);
    exp_q.push_back(`HCX_MODE_WAKE);
    wup();
    complete_run();
  end
endmodule
bind hcx_ctrl hcx_ctrl_monitor #(.TXTO_CYC(TXTO_CYC)) u_mon (.clock_i(clock_i),
  .reset_i(reset_i), .chip_mode_i(chip_mode_i), .mode_wr_data_i(mode_wr_data_i),
  .mode_wr_i(mode_wr_i), .mode_o(mode_o), .tx_data_in_i(tx_data_in_i),
  .rx_data_out_o(rx_data_out_o), .bus_dominant_i(bus_dominant_i),
  .bus_drive_o(bus_drive_o), .rx_enable_o(rx_enable_o), .settled_o(settled_o),
  .fail_o(fail_o), .wake_event_o(wake_event_o));
